// file: rssp_pkg.sv
package rssp_pkg;
	// Bus addressing and control byte layout
	localparam logic [6:0] DEV_ADDR = 7'h32;
	localparam logic [3:0] FMT_WRITE = 4'h0;
	localparam logic [3:0] FMT_DIRECT_READ = 4'h4;
	localparam logic [3:0] PTR_AFTER_STOP = 4'hF;
	localparam logic [7:0] BLOCKED_READ_DATA = 8'hFF;
	localparam int PTR_MSB = 7;
	localparam int PTR_LSB = 4;
	// Timebase and timing figures
	localparam int CLK_PERIOD_NS = 8;
	localparam int CARRY_DELAY_US = 61;
	localparam int CARRY_DELAY_CYC = (CARRY_DELAY_US * 1000) / CLK_PERIOD_NS;
	localparam int TIMEOUT_MIN_MS = 500;
	localparam int TIMEBASE_HZ = 32768;
	localparam int TIMEOUT_TICKS = (TIMEOUT_MIN_MS * TIMEBASE_HZ + 999) / 1000;
	localparam int TICK_W = 15;
	localparam int MASTER_HALF_BIT = 40;
endpackage

// file: rssp_bus_if.sv
interface rssp_bus_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_oe;
	logic sda_s_oe;
	logic scl;
	logic sda;
	// Open-drain wired levels: any enable pulls the line low
	assign scl = ~scl_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);
	modport slave (input scl, input sda, output sda_s_oe);
	modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_oe);
endinterface

// file: rssp_slave.sv
// Behaviour
// - Idle high; start is data fall, clock high
// - Stop is data rise while clock high
// - Only master makes start and stop
// - Eight-bit bytes, receiver acknowledges each
// - Release or start driving at ninth falling edge
// - No master acknowledge: slave releases data
// - Address byte: seven bits MSB first, direction
// - Answer only address 0110010
// - Start without stop is repeated start
// - Control byte: pointer then format code
// - Format 0000 write stores third byte
// - Pointer advances per data byte, wraps
// - Stop loads pointer with Fh
// - Write pointer, repeated start, then read
// - Format 4h: transmit right after control byte
// - Plain read starts at current pointer
// - Hold counters start to stop, carry after
// - Timeout forces stop between 0.5 and 1.0s
// - After timeout: no write ack, reads FFh
// - Timeout counted from first start only
// - Master finishes access within 0.5s
// - Master waits 61us after stop
module rssp_slave
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Bus side
	rssp_bus_if.slave bus,
	// Timebase tick, one cycle per 32.768 kHz period
	input wire logic tick_32k_i,
	// Register side
	output logic [3:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	input wire logic [7:0] reg_rdata_i,
	// Counter hold and deferred carry release
	output logic hold_o,
	output logic carry_apply_o
);
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_RX = 5'h02,
		ST_ACK = 5'h04,
		ST_TX = 5'h08,
		ST_TXACK = 5'h10
	} rssp_state_t;

	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic scl_f;
	logic sda_f;
	logic scl_prev;
	logic sda_prev;
	rssp_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [1:0] byte_idx;
	logic is_read;
	logic ack_drv;
	logic blocked;
	logic [3:0] ptr;
	localparam int TICK_W_L = rssp_pkg::TICK_W;
	logic [TICK_W_L-1:0] tmo_cnt;
	logic [15:0] carry_cnt;
	logic carry_pend;
	localparam logic [TICK_W_L-1:0] TMO_END = TICK_W_L'(rssp_pkg::TIMEOUT_TICKS);
	localparam logic [15:0] CARRY_END = 16'(rssp_pkg::CARRY_DELAY_CYC);

	wire scl_rise = scl_f & ~scl_prev;
	wire scl_fall = ~scl_f & scl_prev;
	wire start_det = scl_f & scl_prev & sda_prev & ~sda_f;
	wire stop_det = scl_f & scl_prev & ~sda_prev & sda_f;
	wire tmo_hit = hold_o & tick_32k_i & (tmo_cnt == TMO_END - 1'b1);
	wire end_access = stop_det | tmo_hit;
	wire tx_bit = shreg[7];

	// Three-stage sampler; a level counts once stages two and three agree
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_s <= {scl_s[1:0], bus.scl};
			sda_s <= {sda_s[1:0], bus.sda};
			if (scl_s[1] == scl_s[2])
				scl_f <= scl_s[2];
			if (sda_s[1] == sda_s[2])
				sda_f <= sda_s[2];
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	// Byte engine; a repeated start simply restarts the address phase
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			byte_idx <= 2'h0;
			is_read <= 1'b0;
			ack_drv <= 1'b0;
			ptr <= rssp_pkg::PTR_AFTER_STOP;
			reg_wr_o <= 1'b0;
			reg_rd_o <= 1'b0;
			reg_addr_o <= 4'h0;
			reg_wdata_o <= 8'h00;
		end
		else
		begin
			reg_wr_o <= 1'b0;
			reg_rd_o <= 1'b0;
			reg_addr_o <= ptr; // Tracks the pointer so read data is ready before the byte loads
			if (end_access)
			begin
				state <= ST_IDLE;
				ack_drv <= 1'b0;
				ptr <= rssp_pkg::PTR_AFTER_STOP;
			end
			else if (start_det)
			begin
				state <= ST_RX;
				bit_cnt <= 4'h0;
				byte_idx <= 2'h0;
				ack_drv <= 1'b0;
			end
			else
			begin
				unique case (state)
					ST_IDLE:
					begin
					end
					ST_RX:
					begin
						if (scl_rise)
						begin
							shreg <= {shreg[6:0], sda_f};
							bit_cnt <= bit_cnt + 4'h1;
						end
						else if (scl_fall && bit_cnt == 4'h8)
						begin
							bit_cnt <= 4'h0;
							if (byte_idx == 2'h0)
							begin
								if (shreg[7:1] == rssp_pkg::DEV_ADDR)
								begin
									state <= ST_ACK;
									ack_drv <= 1'b1;
									is_read <= shreg[0];
								end
								else
									state <= ST_IDLE;
							end
							else if (blocked)
								state <= ST_IDLE;
							else
							begin
								state <= ST_ACK;
								ack_drv <= 1'b1;
								if (byte_idx == 2'h1)
								begin
									ptr <= shreg[rssp_pkg::PTR_MSB:rssp_pkg::PTR_LSB];
									is_read <= (shreg[3:0] == rssp_pkg::FMT_DIRECT_READ);
								end
								else
								begin
									reg_addr_o <= ptr;
									reg_wdata_o <= shreg;
									reg_wr_o <= 1'b1;
									ptr <= ptr + 4'h1;
								end
							end
						end
					end
					ST_ACK:
					begin
						if (scl_fall)
						begin
							ack_drv <= 1'b0;
							if (byte_idx != 2'h3)
								byte_idx <= byte_idx + 2'h1;
							if (is_read)
							begin
								state <= ST_TX;
								shreg <= blocked ? rssp_pkg::BLOCKED_READ_DATA : reg_rdata_i;
								reg_addr_o <= ptr;
								reg_rd_o <= 1'b1;
								ptr <= ptr + 4'h1;
							end
							else
								state <= ST_RX;
						end
					end
					ST_TX:
					begin
						if (scl_fall)
						begin
							if (bit_cnt == 4'h7)
							begin
								bit_cnt <= 4'h0;
								state <= ST_TXACK;
							end
							else
							begin
								bit_cnt <= bit_cnt + 4'h1;
								shreg <= {shreg[6:0], 1'b1};
							end
						end
					end
					ST_TXACK:
					begin
						if (scl_rise)
							state <= sda_f ? ST_IDLE : ST_TXACK;
						else if (scl_fall)
						begin
							state <= ST_TX;
							shreg <= blocked ? rssp_pkg::BLOCKED_READ_DATA : reg_rdata_i;
							reg_addr_o <= ptr;
							reg_rd_o <= 1'b1;
							ptr <= ptr + 4'h1;
						end
					end
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end

	// Open-drain data drive: acknowledge or a zero data bit; released on NACK
	assign bus.sda_s_oe = ack_drv | ((state == ST_TX) & ~tx_bit);

	// Hold and timeout: measured from the first start, repeats do not restart
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			hold_o <= 1'b0;
			tmo_cnt <= '0;
			blocked <= 1'b0;
		end
		else
		begin
			if (end_access)
			begin
				hold_o <= 1'b0;
				tmo_cnt <= '0;
			end
			else if (start_det && !hold_o)
			begin
				hold_o <= 1'b1;
				tmo_cnt <= '0;
			end
			else if (hold_o && tick_32k_i)
				tmo_cnt <= tmo_cnt + 1'b1;
			// The block outlives the forced stop until a fresh access begins
			if (tmo_hit)
				blocked <= 1'b1;
			else if (start_det && !hold_o)
				blocked <= 1'b0;
		end
	end

	// Deferred carry is released CARRY_DELAY_CYC cycles, about 61us, after the access ends
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			carry_pend <= 1'b0;
			carry_cnt <= 16'h0000;
			carry_apply_o <= 1'b0;
		end
		else
		begin
			carry_apply_o <= 1'b0;
			if (end_access)
			begin
				carry_pend <= 1'b1;
				carry_cnt <= 16'h0000;
			end
			else if (carry_pend)
			begin
				carry_cnt <= carry_cnt + 16'h0001;
				if (carry_cnt == CARRY_END - 16'h0001)
				begin
					carry_pend <= 1'b0;
					carry_apply_o <= 1'b1;
				end
			end
		end
	end
endmodule

// file: rssp_master.sv
module rssp_master
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Bus side
	rssp_bus_if.master bus,
	// Command: start, stop, byte write or byte read
	input wire logic cmd_start_i,
	input wire logic cmd_stop_i,
	input wire logic cmd_write_i,
	input wire logic cmd_read_i,
	input wire logic cmd_last_i,
	input wire logic [7:0] cmd_data_i,
	output logic cmd_ready_o,
	// Result
	output logic [7:0] rd_data_o,
	output logic ack_o,
	output logic done_o
);
	typedef enum logic [3:0]
	{
		MS_IDLE = 4'h1,
		MS_START = 4'h2,
		MS_BIT = 4'h4,
		MS_STOP = 4'h8
	} rssp_mstate_t;

	rssp_mstate_t state;
	logic [7:0] half_cnt;
	logic [1:0] phase;
	logic [3:0] bit_cnt;
	logic [8:0] shreg;
	logic rd_mode;
	logic sda_low;
	logic scl_low;
	localparam logic [7:0] HALF = 8'(rssp_pkg::MASTER_HALF_BIT);
	wire tick = (half_cnt == HALF - 8'h01);

	assign cmd_ready_o = (state == MS_IDLE);
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = scl_low;
	assign bus.sda_m_oe = sda_low;

	// Half-bit pacing
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || state == MS_IDLE || tick)
			half_cnt <= 8'h00;
		else
			half_cnt <= half_cnt + 8'h01;
	end

	// Sequencer: data changes only with clock low, except start and stop
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			state <= MS_IDLE;
			phase <= 2'h0;
			bit_cnt <= 4'h0;
			shreg <= 9'h1FF;
			rd_mode <= 1'b0;
			sda_low <= 1'b0;
			scl_low <= 1'b0;
			rd_data_o <= 8'h00;
			ack_o <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			unique case (state)
				MS_IDLE:
				begin
					phase <= 2'h0;
					if (cmd_start_i)
						state <= MS_START;
					else if (cmd_stop_i)
						state <= MS_STOP;
					else if (cmd_write_i || cmd_read_i)
					begin
						state <= MS_BIT;
						bit_cnt <= 4'h0;
						rd_mode <= cmd_read_i;
						// Read: release data, ack unless last wanted byte
						shreg <= cmd_read_i ? {8'hFF, cmd_last_i} : {cmd_data_i, 1'b1};
					end
				end
				MS_START:
					if (tick)
					begin
						phase <= phase + 2'h1;
						unique case (phase)
							2'h0: begin scl_low <= 1'b1; sda_low <= 1'b0; end
							2'h1: scl_low <= 1'b0;
							2'h2: sda_low <= 1'b1;
							default:
							begin
								scl_low <= 1'b1;
								state <= MS_IDLE;
								done_o <= 1'b1;
							end
						endcase
					end
				MS_STOP:
					if (tick)
					begin
						phase <= phase + 2'h1;
						unique case (phase)
							2'h0: begin scl_low <= 1'b1; sda_low <= 1'b1; end
							2'h1: scl_low <= 1'b0;
							2'h2: sda_low <= 1'b0;
							default:
							begin
								state <= MS_IDLE;
								done_o <= 1'b1;
							end
						endcase
					end
				MS_BIT:
					if (tick)
					begin
						// Three steps per bit: set data with clock low, release clock, sample and pull low
						unique case (phase)
							2'h0:
							begin
								sda_low <= ~shreg[8];
								phase <= 2'h1;
							end
							2'h1:
							begin
								scl_low <= 1'b0;
								phase <= 2'h2;
							end
							default:
							begin
								phase <= 2'h0;
								scl_low <= 1'b1;
								shreg <= {shreg[7:0], bus.sda};
								rd_data_o <= rd_mode && bit_cnt < 4'h8 ? {rd_data_o[6:0], bus.sda} : rd_data_o;
								if (bit_cnt == 4'h8)
								begin
									ack_o <= ~bus.sda;
									state <= MS_IDLE;
									done_o <= 1'b1;
								end
								bit_cnt <= bit_cnt + 4'h1;
							end
						endcase
					end
				default:
					state <= MS_IDLE;
			endcase
		end
	end
endmodule

// file: rssp_sva.sv
module rssp_sva
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Bus wires
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_oe,
	// Slave side
	input wire logic tick_32k_i,
	input wire logic hold_o,
	input wire logic carry_apply_o,
	input wire logic reg_wr_o,
	input wire logic [3:0] reg_addr_o
);
	localparam int C_LO = rssp_pkg::CARRY_DELAY_CYC - 4;
	localparam int C_HI = rssp_pkg::CARRY_DELAY_CYC + 12;
	localparam int TO_MIN = rssp_pkg::TIMEOUT_TICKS - 1;
	localparam int TO_MAX = 2 * rssp_pkg::TIMEOUT_TICKS;
	logic scl_d, sda_d, idle, seen, wr_seen, bus_start, bus_stop;
	logic [15:0] since, ticks;
	logic [3:0] last_wr;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// Start and stop seen on the wired levels
	assign bus_start = scl && scl_d && sda_d && !sda;
	assign bus_stop = scl && scl_d && !sda_d && sda;
	always_ff @(posedge clk_sys_i)
	begin
		scl_d <= scl;
		sda_d <= sda;
	end
	// Idle from stop to next start, so repeated starts are told apart
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			idle <= 1'b1;
		else if (bus_start)
			idle <= 1'b0;
		else if (bus_stop)
			idle <= 1'b1;
	end
	// Cycles since the access ended; saturates so a quiet bus never wraps
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			since <= 16'hFFFF;
		else if (hold_o)
			since <= 16'h0000;
		else if (since != 16'hFFFF)
			since <= since + 16'h0001;
	end
	// Carry pulse seen since the access ended
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || hold_o)
			seen <= 1'b0;
		else if (carry_apply_o)
			seen <= 1'b1;
	end
	// Timebase ticks while held, never cleared by a repeated start
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || !hold_o)
			ticks <= 16'h0000;
		else if (tick_32k_i)
			ticks <= ticks + 16'h0001;
	end
	// Last stored register within one access
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || !hold_o)
			wr_seen <= 1'b0;
		else if (reg_wr_o)
			wr_seen <= 1'b1;
		if (reg_wr_o)
			last_wr <= reg_addr_o;
	end
	property p_start_hold;
		bus_start && idle |-> ##[1:10] hold_o;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("hold not raised after start");
	property p_stop_free;
		bus_stop |-> ##[1:10] !hold_o;
	endproperty
	a_stop_free: assert property (p_stop_free) else $error("hold kept after stop");
	property p_carry_win;
		carry_apply_o |-> since >= C_LO && since <= C_HI;
	endproperty
	a_carry_win: assert property (p_carry_win) else $error("carry pulse off its slot");
	property p_carry_due;
		since == C_HI + 1 |-> seen;
	endproperty
	a_carry_due: assert property (p_carry_due) else $error("carry pulse missing");
	property p_sda_steady;
		scl && scl_d && hold_o |-> $stable(sda_s_oe);
	endproperty
	a_sda_steady: assert property (p_sda_steady) else $error("slave moved data with clock high");
	property p_to_max;
		hold_o |-> ticks < TO_MAX;
	endproperty
	a_to_max: assert property (p_to_max) else $error("access held too long");
	property p_to_min;
		$fell(hold_o) && !idle |-> ticks >= TO_MIN;
	endproperty
	a_to_min: assert property (p_to_min) else $error("access ended too early");
	property p_idle_quiet;
		idle |-> !sda_s_oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("slave drives idle bus");
	property p_wr_incr;
		reg_wr_o && wr_seen |-> reg_addr_o == last_wr + 4'h1;
	endproperty
	a_wr_incr: assert property (p_wr_incr) else $error("pointer did not advance");
	c_timeout: cover property ($fell(hold_o) && !idle);
	c_carry: cover property (carry_apply_o);
	c_restart: cover property (bus_start && hold_o);
endmodule

// file: tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] AW = {rssp_pkg::DEV_ADDR, 1'b0};
	localparam logic [7:0] AR = {rssp_pkg::DEV_ADDR, 1'b1};
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic tick_32k_i = 1'b0;
	logic cmd_start = 1'b0, cmd_stop = 1'b0, cmd_write = 1'b0, cmd_read = 1'b0, cmd_last = 1'b0;
	logic [7:0] cmd_data = 8'h00;
	logic [7:0] reg_wdata, rd_data, wr_data, reg_rdata;
	logic [3:0] reg_addr, wr_addr;
	logic reg_wr, hold, carry, ready, ack, done;
	int wr_cnt = 0, tick_div = 256, tcnt = 0, num_errors = 0, samples_checked = 0;
	rssp_bus_if rssp_bus_if_i();
	rssp_slave rssp_slave_i(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus(rssp_bus_if_i), .tick_32k_i(tick_32k_i),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(), .reg_rdata_i(reg_rdata),
		.hold_o(hold), .carry_apply_o(carry));
	rssp_master rssp_master_i(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus(rssp_bus_if_i),
		.cmd_start_i(cmd_start), .cmd_stop_i(cmd_stop), .cmd_write_i(cmd_write), .cmd_read_i(cmd_read),
		.cmd_last_i(cmd_last), .cmd_data_i(cmd_data), .cmd_ready_o(ready), .rd_data_o(rd_data), .ack_o(ack),
		.done_o(done));
	rssp_sva rssp_sva_i(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl(rssp_bus_if_i.scl),
		.sda(rssp_bus_if_i.sda), .sda_s_oe(rssp_bus_if_i.sda_s_oe), .tick_32k_i(tick_32k_i), .hold_o(hold),
		.carry_apply_o(carry), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr));
	// Register contents differ at every address
	assign reg_rdata = {~reg_addr, reg_addr};
	always #4 clk_sys_i = ~clk_sys_i;
	// Timebase; one tick per tick_div cycles, and tick_div of 1 shortens the timeout to a usable run
	always @(negedge clk_sys_i)
	begin
		tcnt <= tcnt + 1;
		tick_32k_i <= (tcnt % tick_div) == 0;
	end
	// Record stores seen on the register side
	always @(posedge clk_sys_i)
		if (reg_wr)
		begin
			wr_addr <= reg_addr;
			wr_data <= reg_wdata;
			wr_cnt <= wr_cnt + 1;
		end
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask
	// Bounded wait at falling edges: 0 ready, 1 done, 2 hold
	task automatic wait_for(input int w, input logic lv, input int lim);
		int n;
		n = 0;
		while ((w == 0 ? ready : w == 1 ? done : hold) !== lv)
		begin
			@(negedge clk_sys_i);
			n++;
			if (n > lim)
			begin
				num_errors++;
				close_out();
			end
		end
	endtask
	// Command held to the edge that takes it: 0 start, 1 stop, 2 write, 3 read
	task automatic cmd(input int k, input logic [7:0] d, input logic last);
		@(negedge clk_sys_i);
		wait_for(0, 1'b1, 100);
		{cmd_start, cmd_stop, cmd_write, cmd_read} = 4'h8 >> k;
		cmd_data = d;
		cmd_last = last;
		@(negedge clk_sys_i);
		{cmd_start, cmd_stop, cmd_write, cmd_read, cmd_last} = 5'h00;
		wait_for(1, 1'b1, 4000);
	endtask
	task automatic wr(input logic [7:0] d, input logic a);
		cmd(2, d, 1'b0);
		chk({7'h00, ack}, {7'h00, a});
	endtask
	task automatic rd(input logic last, input logic [3:0] a);
		cmd(3, 8'h00, last);
		chk(rd_data, {~a, a});
	endtask
	task automatic stop();
		cmd(1, 8'h00, 1'b0);
		repeat (rssp_pkg::CARRY_DELAY_CYC + 40) @(negedge clk_sys_i);
		chk({7'h00, hold}, 8'h00);
	endtask
	initial
	begin
		repeat (2) @(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		// Store across the top of the pointer range
		cmd(0, 8'h00, 1'b0);
		wr(AW, 1'b1);
		wr(8'hF0, 1'b1);
		wr(8'h5A, 1'b1);
		chk({wr_addr, wr_data[7:4]}, 8'hF5);
		wr(8'hC3, 1'b1);
		chk({wr_addr, wr_data[7:4]}, 8'h0C);
		chk(8'(wr_cnt), 8'h02);
		chk({7'h00, hold}, 8'h01);
		stop();
		// Pointer written, then repeated start and read
		cmd(0, 8'h00, 1'b0);
		wr(AW, 1'b1);
		wr(8'h20, 1'b1);
		cmd(0, 8'h00, 1'b0);
		wr(AR, 1'b1);
		rd(1'b1, 4'h2);
		stop();
		// Immediate read across the wrap
		cmd(0, 8'h00, 1'b0);
		wr(AW, 1'b1);
		wr(8'hE4, 1'b1);
		rd(1'b0, 4'hE);
		rd(1'b0, 4'hF);
		rd(1'b1, 4'h0);
		stop();
		// Neighbour address ignored, then plain read from the stop value
		cmd(0, 8'h00, 1'b0);
		wr(8'h66, 1'b0);
		cmd(0, 8'h00, 1'b0);
		wr(AR, 1'b1);
		rd(1'b1, 4'hF);
		stop();
		// Stalled access cut short, timed from the first start
		tick_div = 1;
		cmd(0, 8'h00, 1'b0);
		wr(AW, 1'b1);
		wr(8'h30, 1'b1);
		cmd(0, 8'h00, 1'b0);
		wr(AW, 1'b1);
		wait_for(2, 1'b0, 20000);
		wr(8'h77, 1'b0);
		chk(8'(wr_cnt), 8'h02);
		cmd(3, 8'h00, 1'b1);
		chk(rd_data, rssp_pkg::BLOCKED_READ_DATA);
		// Let the deferred carry of the cut access land before a fresh access
		repeat (rssp_pkg::CARRY_DELAY_CYC + 40) @(negedge clk_sys_i);
		cmd(0, 8'h00, 1'b0);
		wr(AR, 1'b1);
		rd(1'b1, 4'hF);
		stop();
		close_out();
	end
endmodule
